// ===== hdl/scp_pkg.sv
// Constants for the serial configuration port controller.
// Assumes a 100 MHz ref_clk that oversamples the serial pins.
`default_nettype none
package scp_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int REF_CLK_HZ = 100000000;
  localparam int SCLK_MAX_HZ = 20000000;
  // Reference cycles in the shortest serial clock period
  localparam int SCLK_MIN_CYCLES = REF_CLK_HZ / SCLK_MAX_HZ;

  // ****************************************************************
  // Frame layout
  // ****************************************************************
  localparam int BYTE_BITS = 8;
  localparam int ADDR_BITS = 7;
  localparam int NUM_REGS = 128;
  localparam int INSTR_RW_BIT = 7;
  localparam logic [2:0] LAST_BIT_IDX = 3'h7;

  // ****************************************************************
  // Port configuration register
  // ****************************************************************
  localparam logic [6:0] CFG_REG_ADDR = 7'h00;
  localparam int CFG_BIDIR_BIT = 7;
  localparam int CFG_LSB_FIRST_BIT = 6;
  localparam int CFG_SOFT_RST_BIT = 5;
  localparam logic [7:0] CFG_RESET_VAL = 8'h80;
  localparam logic [7:0] REG_RESET_VAL = 8'h00;

  // Serial controller phases
  typedef enum logic [1:0] {
    SCP_INSTR = 2'b00,
    SCP_DATA = 2'b01
  } scp_phase_t;

endpackage : scp_pkg

`default_nettype wire

// ===== hdl/scp_port.sv
// Serial configuration port: instruction byte then one data byte.
// Assumes sclk, cs_n and data pins come from an outside master and are
// oversampled by ref_clk; the wire level is resolved from the enables.
//
// Behaviour
// - First eight rising edges carry instruction
// - Instruction decides direction and register address
// - Exactly one data byte follows instruction
// - Write lands on last data bit
// - Chip select stall on byte boundary resumes
// - Stall mid-byte returns to instruction state
// - Instruction bit 7: one reads, zero writes
// - Instruction bits 6..0 give register address
// - Both MSB-first and LSB-first orders supported
// - Bidirectional pin or separate in/out pins
// - Every register readable and writable
// - Sample and launch on rising serial edges
// - Chip select high floats both outputs
// - Config bit 7 picks pin mode, default one
// - Config bit 6 picks bit order, default zero
`timescale 1ns/10ps
`default_nettype none

module scp_port
  import scp_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Serial pins from the master
  input wire logic sclk,
  input wire logic cs_n,
  // Bidirectional data pin
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  // Separate output pin
  output logic serial_out_pin,
  output logic serial_out_pin_oe,
  // Port configuration seen by the device
  output logic cfg_bidir,
  output logic cfg_lsb_first,
  // Register write notification
  output logic reg_wr_strobe,
  output logic [6:0] reg_wr_addr,
  output logic [7:0] reg_wr_data,
  output logic soft_reset_pulse
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [1:0] sclk_sync_reg;
  logic [1:0] cs_sync_reg;
  logic [1:0] din_sync_reg;
  logic sclk_prev_reg;

  // Two flops per pin, then one more for sclk edge finding
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sclk_sync_reg <= 2'h0;
      cs_sync_reg <= 2'h3;
      din_sync_reg <= 2'h0;
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[0], sclk};
      cs_sync_reg <= {cs_sync_reg[0], cs_n};
      din_sync_reg <= {din_sync_reg[0], sdio_in};
      sclk_prev_reg <= sclk_sync_reg[1];
    end
  end

  logic sclk_rise;
  logic cs_active;
  logic din;
  assign sclk_rise = sclk_sync_reg[1] & ~sclk_prev_reg;
  assign cs_active = ~cs_sync_reg[1];
  assign din = din_sync_reg[1];

  // ****************************************************************
  // Register array
  // ****************************************************************
  logic [7:0] regs_mem [NUM_REGS];
  logic [7:0] cfg_byte;
  assign cfg_byte = regs_mem[CFG_REG_ADDR];
  assign cfg_bidir = cfg_byte[CFG_BIDIR_BIT];
  assign cfg_lsb_first = cfg_byte[CFG_LSB_FIRST_BIT];

  // Shift in one bit in the selected order
  function automatic logic [7:0] shift_in(input logic [7:0] sr,
                                          input logic bit_in,
                                          input logic lsb_first);
    if (lsb_first) begin
      shift_in = {bit_in, sr[7:1]};
    end else begin
      shift_in = {sr[6:0], bit_in};
    end
  endfunction : shift_in

  // Pick the outgoing bit for a position in the selected order
  function automatic logic pick_bit(input logic [7:0] data,
                                    input logic [2:0] idx,
                                    input logic lsb_first);
    if (lsb_first) begin
      pick_bit = data[idx];
    end else begin
      pick_bit = data[LAST_BIT_IDX - idx];
    end
  endfunction : pick_bit

  // ****************************************************************
  // Serial controller
  // ****************************************************************
  scp_phase_t phase_reg, phase_next;
  logic [2:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic rd_reg, rd_next;
  logic [6:0] addr_reg, addr_next;
  logic [7:0] rd_byte_reg, rd_byte_next;
  logic out_bit_reg, out_bit_next;
  logic wr_en;
  logic [7:0] wr_byte;
  logic [7:0] shifted;

  // Next state of the controller
  always_comb begin
    phase_next = phase_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    rd_next = rd_reg;
    addr_next = addr_reg;
    rd_byte_next = rd_byte_reg;
    out_bit_next = out_bit_reg;
    wr_en = 1'b0;
    shifted = shift_in(shift_reg, din, cfg_lsb_first);
    wr_byte = shifted;
    if (!cs_active) begin
      // Stall is kept only on a byte boundary
      if (bit_cnt_reg != 3'h0) begin
        phase_next = SCP_INSTR;
        bit_cnt_next = 3'h0;
      end
    end else if (sclk_rise) begin
      shift_next = shifted;
      bit_cnt_next = bit_cnt_reg + 3'h1;
      if (phase_reg == SCP_DATA && rd_reg) begin
        // Launch the next read bit on this rising edge
        out_bit_next = pick_bit(rd_byte_reg, bit_cnt_reg + 3'h1,
                                cfg_lsb_first);
      end
      if (bit_cnt_reg == LAST_BIT_IDX) begin
        case (phase_reg)
          SCP_INSTR: begin
            phase_next = SCP_DATA;
            rd_next = shifted[INSTR_RW_BIT];
            addr_next = shifted[ADDR_BITS-1:0];
            rd_byte_next = regs_mem[shifted[ADDR_BITS-1:0]];
            out_bit_next = pick_bit(regs_mem[shifted[ADDR_BITS-1:0]],
                                    3'h0, cfg_lsb_first);
          end
          SCP_DATA: begin
            phase_next = SCP_INSTR;
            wr_en = ~rd_reg;
          end
          default: begin
            phase_next = SCP_INSTR;
          end
        endcase
      end
    end
  end

  // Controller registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      phase_reg <= SCP_INSTR;
      bit_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      rd_reg <= 1'b0;
      addr_reg <= 7'h00;
      rd_byte_reg <= 8'h00;
      out_bit_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      rd_reg <= rd_next;
      addr_reg <= addr_next;
      rd_byte_reg <= rd_byte_next;
      out_bit_reg <= out_bit_next;
    end
  end

  // ****************************************************************
  // Register writes and soft reset
  // ****************************************************************
  logic soft_rst;
  logic [7:0] cfg_wr;
  assign soft_rst = wr_en && addr_reg == CFG_REG_ADDR &&
                    wr_byte[CFG_SOFT_RST_BIT];
  // Soft reset bit self-clears; config byte keeps the rest
  assign cfg_wr = wr_byte & ~(8'h01 << CFG_SOFT_RST_BIT);

  // Array update; soft reset restores all but the config byte
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_mem[i] <= (i == 0) ? CFG_RESET_VAL : REG_RESET_VAL;
      end
    end else if (soft_rst) begin
      for (int i = 1; i < NUM_REGS; i++) begin
        regs_mem[i] <= REG_RESET_VAL;
      end
      regs_mem[CFG_REG_ADDR] <= cfg_wr;
    end else if (wr_en) begin
      regs_mem[addr_reg] <= (addr_reg == CFG_REG_ADDR) ?
                            cfg_wr : wr_byte;
    end
  end

  // Write notification outputs
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_wr_strobe <= 1'b0;
      reg_wr_addr <= 7'h00;
      reg_wr_data <= 8'h00;
      soft_reset_pulse <= 1'b0;
    end else begin
      reg_wr_strobe <= wr_en;
      reg_wr_addr <= wr_en ? addr_reg : reg_wr_addr;
      reg_wr_data <= wr_en ? wr_byte : reg_wr_data;
      soft_reset_pulse <= soft_rst;
    end
  end

  // ****************************************************************
  // Output pins
  // ****************************************************************
  logic read_drive;
  // Drive only while selected and in a read data phase
  assign read_drive = cs_active && phase_reg == SCP_DATA && rd_reg;
  assign sdio_out = out_bit_reg;
  assign serial_out_pin = out_bit_reg;
  assign sdio_oe = read_drive & cfg_bidir;
  assign serial_out_pin_oe = read_drive & ~cfg_bidir;

endmodule : scp_port

`default_nettype wire

// ===== testbench/scp_props.sv
// Assertion checker for the serial configuration port.
// Bound into scp_port; watches its ports only.
`timescale 1ns/10ps
`default_nettype none
module scp_props
  import scp_pkg::*;
(
  // Watched ports
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic sdio_out,
  input wire logic sdio_oe,
  input wire logic serial_out_pin,
  input wire logic serial_out_pin_oe,
  input wire logic cfg_bidir,
  input wire logic cfg_lsb_first,
  input wire logic reg_wr_strobe,
  input wire logic [6:0] reg_wr_addr,
  input wire logic [7:0] reg_wr_data
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Pin and write checks
  wire logic oe_any = sdio_oe | serial_out_pin_oe;
  a_cs_floats: assert property (cs_n [*6] |-> !oe_any)
    else $error("pin driven while idle");
  a_oe_mode: assert property (oe_any
    |-> {sdio_oe, serial_out_pin_oe} == {cfg_bidir, !cfg_bidir})
    else $error("wrong pin driven");
  a_pins_same: assert property (oe_any |-> sdio_out == serial_out_pin)
    else $error("output pins differ");
  // A launched read bit holds well past one serial half period
  a_bit_steady: assert property (oe_any && $changed(sdio_out)
    |=> $stable(sdio_out) [*8])
    else $error("read bit changed too soon");
  a_read_span: assert property ($rose(oe_any) |-> oe_any [*8])
    else $error("read phase cut short");
  a_strobe_once: assert property (reg_wr_strobe |=> !reg_wr_strobe)
    else $error("write strobe too long");
  a_idle_no_wr: assert property (cs_n [*8] |-> !reg_wr_strobe)
    else $error("write while idle");
  a_cfg_follow: assert property (reg_wr_strobe
    && reg_wr_addr == CFG_REG_ADDR |-> {cfg_bidir, cfg_lsb_first}
    == reg_wr_data[7:6]) else $error("config not updated");
  a_cfg_reset: assert property ($rose(nrst)
    |-> cfg_bidir && !cfg_lsb_first) else $error("config reset wrong");
  // Main scenarios
  cover property ($rose(sdio_oe));
  cover property ($rose(serial_out_pin_oe));
  cover property (reg_wr_strobe && reg_wr_addr == CFG_REG_ADDR);
endmodule : scp_props
bind scp_port scp_props chk_u (.*);
`default_nettype wire

// ===== testbench/scp_master.sv
// Serial master model for the configuration port.
// Bench sets lsb and bid to match the port setup, and sets stall for writes.
`timescale 1ns/10ps
`default_nettype none
module scp_master (
  // Serial pins
  output logic sclk,
  output logic cs_n,
  output logic sdio_in,
  // Port answers
  input wire logic sdio_out,
  input wire logic sdio_oe,
  input wire logic serial_out_pin,
  input wire logic serial_out_pin_oe
);
  logic lsb = 1'b0, bid = 1'b1, stall = 1'b0, mb = 1'b0;
  // Port drives the wire when enabled, else master or flipped level
  assign sdio_in = sdio_oe ? sdio_out : mb;
  // Idle pins
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
  end
  // Instruction byte then one data byte; cut drops select mid-byte
  task automatic xfer(input logic [7:0] ins, dat, input int cut,
    output logic [7:0] rd);
    int p;
    rd = 8'h00;
    cs_n = 1'b0;
    for (int i = 0; i < 16; i++) begin
      p = lsb ? i % 8 : 7 - i % 8;
      if (i == 8 && stall || i == cut) cs_n = 1'b1;
      if (i == cut) #500 return;
      if (i == 8 && stall) #500 cs_n = 1'b0;
      mb = i < 8 ? ins[p] : ins[7] ? mb ^ (i == 8) : dat[p];
      #62.5;
      if (i > 7 && ins[7]) rd[p] = bid ? sdio_in :
        serial_out_pin_oe ? serial_out_pin : 1'bx;
      sclk = 1'b1;
      #62.5 sclk = 1'b0;
    end
    #125 cs_n = 1'b1;
    #250;
  endtask : xfer
endmodule : scp_master
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench for the serial configuration port.
// Drives the port through scp_master; an array models the registers.
`timescale 1ns/10ps
`default_nettype none
module testbench
  import scp_pkg::*;
;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  wire logic sclk, cs_n, sdio_in, sdio_out, sdio_oe, serial_out_pin;
  wire logic serial_out_pin_oe, cfg_bidir, cfg_lsb_first, reg_wr_strobe;
  wire logic soft_reset_pulse;
  wire logic [6:0] reg_wr_addr;
  wire logic [7:0] reg_wr_data;
  logic [7:0] mem [128];
  logic [7:0] modes [5] = '{8'h80, 8'hc0, 8'h40, 8'h00, 8'ha0};
  logic [6:0] a = 7'h11;
  int n_fail = 0, check_count = 0, n_wr = 0, n_sr = 0, e_wr = 0, e_sr = 0;
  int seed = 32'he0f9017a;
  // Port and serial master
  scp_port dut_u (.*);
  scp_master m_u (.*);
  // Clock and pulse counts
  initial forever #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    n_wr += reg_wr_strobe === 1'b1;
    n_sr += soft_reset_pulse === 1'b1;
  end
  // Compare one value
  task automatic chk(input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp) n_fail++;
    if (seen !== exp) $display("wrong value at %0t: %h", $time, seen);
  endtask : chk
  // One serial cycle; the model follows writes and config
  task automatic acc(input logic rw, input logic [6:0] ad,
    input logic [7:0] d, input int cut);
    logic [7:0] r;
    @(posedge ref_clk);
    #1 m_u.stall = !rw;
    m_u.xfer({rw, ad}, d, cut, r);
    if (cut > 15 && rw) chk(r, mem[ad]);
    if (cut > 15 && !rw) begin
      e_wr++;
      chk({1'b0, reg_wr_addr}, {1'b0, ad});
      chk(reg_wr_data, d);
      mem[ad] = ad ? d : d & 8'hdf;
      if (ad == CFG_REG_ADDR) {m_u.bid, m_u.lsb} = d[7:6];
      if (ad == CFG_REG_ADDR && d[5]) e_sr++;
      if (ad == CFG_REG_ADDR && d[5]) foreach (mem[k]) if (k) mem[k] = 0;
    end
    chk(8'(n_wr - e_wr), 8'h00);
  endtask : acc
  // Verdict
  task automatic test_done();
    $display("%0d checks, %0d wrong", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  // Hang guard
  initial begin
    #1000000 n_fail++;
    test_done();
  end
  // Every pin mode and bit order, stalls, aborts, soft reset
  initial begin
    foreach (mem[k]) mem[k] = k ? 8'h00 : CFG_RESET_VAL;
    repeat (5) @(posedge ref_clk);
    #1 nrst = 1'b1;
    repeat (3) @(posedge ref_clk);
    chk({6'h00, cfg_bidir, cfg_lsb_first}, 8'h02);
    foreach (modes[j]) begin
      acc(1'b0, CFG_REG_ADDR, modes[j], 16);
      acc(1'b1, CFG_REG_ADDR, 8'h00, 16);
      acc(1'b1, a, 8'h00, 16);
      repeat (3) begin
        a = 7'($random(seed)) | 7'h01;
        acc(1'b0, a, 8'($random(seed)), 16);
        acc(1'b0, a, ~mem[a],
          1 + 8 * (j % 2) + $unsigned($random(seed)) % 7);
        acc(1'b1, a, 8'h00, 16);
      end
      $display("mode %h done", modes[j]);
    end
    chk(8'(n_sr), 8'(e_sr));
    test_done();
  end
endmodule : testbench
`default_nettype wire
